// *** logic/dec_skip_int_enable_hold_exec.sv ***
// Executor for decrement-skip-if-zero, interrupt enable/disable and hold
// Behaviour
// [RL1] Decrement nibble into accumulator and memory, flags
// [RL2] Zero result advances counter by two
// [RL3] Enable word sets global interrupt enable
// [RL4] Hold left only by interrupt or release
// [RL5] Interrupt in hold starts service routine
// [RL6] Enabled release condition ends hold directly
// [RL7] Return after hold interrupt re-enters hold; a release seen in the routine sends the core to run mode instead
// [RL8] Disable word clears global interrupt enable
// [RL9] Each instruction completes in one cycle
`timescale 1ns/100ps
module dec_skip_int_enable_hold_exec (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR,
   input wire logic [3:0] MEM_RDATA,
   input wire logic INT_REQ,
   input wire logic [10:0] INT_VECTOR,
   input wire logic RETURN_EXEC,
   input wire logic [7:0] HOLD_RELEASE_EN,
   input wire logic [7:0] HOLD_RELEASE_EVENTS,
   output logic [10:0] PC,
   output logic [3:0] ACCUMULATOR,
   output logic CARRY_FLAG,
   output logic ZERO_FLAG,
   output logic [6:0] MEM_ADDR,
   output logic [3:0] MEM_WDATA,
   output logic MEM_WE,
   output logic INT_ENABLE,
   output logic INT_ACCEPT,
   output logic HOLD_MODE
);
   exec_pkg::mode_t mode_ff, nxt_mode;
   logic [10:0] pc_ff, nxt_pc;
   logic [10:0] ret_pc_ff, nxt_ret_pc;
   logic [3:0] accum_ff, nxt_accum;
   logic carry_ff, nxt_carry;
   logic zero_ff, nxt_zero;
   logic [6:0] addr_ff, nxt_addr;
   logic [3:0] wdata_ff, nxt_wdata;
   logic we_ff, nxt_we;
   logic ie_ff, nxt_ie;
   logic accept_ff;
   logic in_hold;
   logic int_take;
   logic release_hit;
   logic exec;
   logic is_dec_skip;
   logic [6:0] instr_addr;
   logic [10:0] pc_seq;
   logic [10:0] pc_adv;
   logic hold_taken;
   logic is_en;
   logic is_dis;
   logic is_hold;
   logic skip;
   logic [10:0] pc_step;

   dec_if dp ();

   nibble_decrement u_dec (
      .dp(dp)
   );

   // Instruction decode; the low seven bits address the nibble
   assign instr_addr = INSTR[exec_pkg::ADDR_W-1:0];
   assign is_dec_skip = (INSTR[exec_pkg::INSTR_W-1:exec_pkg::ADDR_W] == exec_pkg::DEC_SKIP_OP); // [RL1]
   assign is_en = (INSTR == exec_pkg::INT_ENABLE_OP); // [RL3]
   assign is_dis = (INSTR == exec_pkg::INT_DISABLE_OP); // [RL8]
   assign is_hold = (INSTR == exec_pkg::HOLD_OP);

   // Interrupt acceptance and hold release
   assign in_hold = (mode_ff == exec_pkg::MODE_HOLD);
   assign int_take = INT_REQ & ie_ff & (in_hold | INSTR_VALID); // [RL5]
   assign release_hit = |(HOLD_RELEASE_EVENTS & HOLD_RELEASE_EN); // [RL6]
   assign exec = INSTR_VALID & ~in_hold & ~int_take; // [RL4]

   // Decrement datapath and program counter step
   assign dp.operand = MEM_RDATA;
   assign skip = is_dec_skip & dp.zero; // [RL2]
   assign pc_step = skip ? exec_pkg::PC_STEP_SKIP : exec_pkg::PC_STEP_ONE; // [RL2]

   // Counter values for the plain step, the taken step and hold entry
   assign pc_seq = pc_ff + exec_pkg::PC_STEP_ONE;
   assign pc_adv = pc_ff + pc_step; // [RL2] [RL9]
   assign hold_taken = exec & is_hold; // [RL4]

   // Next-state logic, one instruction per cycle
   always_comb begin
      nxt_mode = mode_ff;
      nxt_pc = pc_ff;
      nxt_ret_pc = ret_pc_ff;
      nxt_accum = accum_ff;
      nxt_carry = carry_ff;
      nxt_zero = zero_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_we = 1'b0;
      nxt_ie = ie_ff;
      unique case (mode_ff)
         exec_pkg::MODE_RUN: begin
            if (int_take) begin
               nxt_ret_pc = pc_ff;
               nxt_pc = INT_VECTOR;
            end else if (RETURN_EXEC) begin
               nxt_pc = ret_pc_ff;
            end else if (hold_taken) begin
               nxt_pc = pc_seq;
               nxt_mode = exec_pkg::MODE_HOLD; // [RL4]
            end
         end
         exec_pkg::MODE_HOLD: begin
            if (int_take) begin
               nxt_ret_pc = pc_ff;
               nxt_pc = INT_VECTOR; // [RL5]
               nxt_mode = exec_pkg::MODE_ISR_HOLD; // [RL5]
            end else if (release_hit) begin
               nxt_mode = exec_pkg::MODE_RUN; // [RL6]
            end
         end
         exec_pkg::MODE_ISR_HOLD: begin
            if (int_take) begin
               nxt_ret_pc = pc_ff;
               nxt_pc = INT_VECTOR;
            end else if (RETURN_EXEC) begin
               nxt_pc = ret_pc_ff;
               nxt_mode = release_hit ? exec_pkg::MODE_RUN : exec_pkg::MODE_HOLD; // [RL7]
            end else if (hold_taken) begin
               // A hold word in the routine is taken even with a release pending
               nxt_pc = pc_seq;
               nxt_mode = exec_pkg::MODE_HOLD; // [RL4]
            end else if (release_hit) begin
               nxt_mode = exec_pkg::MODE_RUN; // [RL6]
            end
         end
      endcase
      // Ordinary instruction effects, completed in the cycle taken
      if (exec && !RETURN_EXEC) begin
         if (!is_hold) begin
            nxt_pc = pc_adv; // [RL2] [RL9]
         end
         if (is_dec_skip) begin
            nxt_accum = dp.result; // [RL1]
            nxt_carry = dp.carry; // [RL1]
            nxt_zero = dp.zero; // [RL1]
            nxt_addr = instr_addr; // [RL1]
            nxt_wdata = dp.result; // [RL1]
            nxt_we = 1'b1; // [RL1] [RL9]
         end
         if (is_en) begin
            nxt_ie = 1'b1; // [RL3]
         end
         if (is_dis) begin
            nxt_ie = 1'b0; // [RL8]
         end
      end
   end

   // Mode, program counter and single return address
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         mode_ff <= exec_pkg::MODE_RUN;
         pc_ff <= exec_pkg::PC_RESET;
         ret_pc_ff <= exec_pkg::PC_RESET;
      end else begin
         mode_ff <= nxt_mode;
         pc_ff <= nxt_pc;
         ret_pc_ff <= nxt_ret_pc;
      end
   end

   // Accumulator and flags
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         accum_ff <= exec_pkg::ACCUM_RESET;
         carry_ff <= exec_pkg::CARRY_RESET;
         zero_ff <= exec_pkg::ZERO_RESET;
      end else begin
         accum_ff <= nxt_accum;
         carry_ff <= nxt_carry;
         zero_ff <= nxt_zero;
      end
   end

   // Global interrupt enable, changed only by instruction
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ie_ff <= exec_pkg::IE_RESET;
      end else begin
         ie_ff <= nxt_ie;
      end
   end

   // Memory write port
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         addr_ff <= exec_pkg::ADDR_RESET;
         wdata_ff <= exec_pkg::NIB_ZERO;
         we_ff <= 1'b0;
      end else begin
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         we_ff <= nxt_we;
      end
   end

   // Acceptance strobe, one cycle after the take
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         accept_ff <= 1'b0;
      end else begin
         accept_ff <= int_take;
      end
   end

   // Outputs straight from flops
   assign PC = pc_ff;
   assign ACCUMULATOR = accum_ff;
   assign CARRY_FLAG = carry_ff;
   assign ZERO_FLAG = zero_ff;
   assign MEM_ADDR = addr_ff;
   assign MEM_WDATA = wdata_ff;
   assign MEM_WE = we_ff;
   assign INT_ENABLE = ie_ff;
   assign INT_ACCEPT = accept_ff;
   assign HOLD_MODE = mode_ff[1];
endmodule

// *** logic/exec_pkg.sv ***
// Constants, opcodes and state codes for the skip, interrupt-enable and hold executor
package exec_pkg;
   localparam int INSTR_W = 16;
   localparam int NIB_W = 4;
   localparam int ADDR_W = 7;
   localparam int PC_W = 11;
   localparam int REL_FLAG_W = 8;

   // Opcode of the decrement-skip-if-zero group: upper nine bits fixed, low seven are the address
   localparam int DEC_SKIP_OP_W = 9;
   localparam logic [8:0] DEC_SKIP_OP = 9'h090;
   localparam logic [15:0] INT_ENABLE_OP = 16'h50e0;
   localparam logic [15:0] INT_DISABLE_OP = 16'h50c0;
   localparam logic [15:0] HOLD_OP = 16'h0080;

   // Decrement operand and program counter steps
   localparam logic [3:0] DEC_ONE = 4'h1;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [10:0] PC_STEP_ONE = 11'h001;
   localparam logic [10:0] PC_STEP_SKIP = 11'h002;

   // Reset values
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [3:0] ACCUM_RESET = 4'h0;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic IE_RESET = 1'b0;

   // Core mode: running, held, or servicing an interrupt taken out of hold
   typedef enum logic [2:0] {
      MODE_RUN = 3'b001,
      MODE_HOLD = 3'b010,
      MODE_ISR_HOLD = 3'b100
   } mode_t;
endpackage

// *** logic/dec_if.sv ***
// Carrier between the executor and its decrement unit
`timescale 1ns/100ps
interface dec_if;
   logic [exec_pkg::NIB_W-1:0] operand;
   logic [exec_pkg::NIB_W-1:0] result;
   logic carry;
   logic zero;

   modport user (output operand, input result, carry, zero);
   modport unit (input operand, output result, carry, zero);
endinterface

// *** logic/nibble_decrement.sv ***
// Four-bit decrement with carry and zero results
`timescale 1ns/100ps
module nibble_decrement (
   dec_if.unit dp
);
   logic [exec_pkg::NIB_W:0] diff;

   // Extra top bit catches the borrow out of the nibble
   assign diff = {1'b0, dp.operand} - {1'b0, exec_pkg::DEC_ONE}; // [RL1]
   assign dp.result = diff[exec_pkg::NIB_W-1:0]; // [RL1]
   assign dp.carry = ~diff[exec_pkg::NIB_W]; // [RL1]
   assign dp.zero = (diff[exec_pkg::NIB_W-1:0] == exec_pkg::NIB_ZERO); // [RL1]
endmodule

// *** testbench/exec_checker.sv ***
// Checker for the executor ports
`timescale 1ns/100ps
module exec_checker (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR,
   input wire logic [3:0] MEM_RDATA,
   input wire logic INT_REQ,
   input wire logic [10:0] INT_VECTOR,
   input wire logic RETURN_EXEC,
   input wire logic [7:0] HOLD_RELEASE_EN,
   input wire logic [7:0] HOLD_RELEASE_EVENTS,
   input wire logic [10:0] PC,
   input wire logic [3:0] ACCUMULATOR,
   input wire logic CARRY_FLAG,
   input wire logic ZERO_FLAG,
   input wire logic [6:0] MEM_ADDR,
   input wire logic [3:0] MEM_WDATA,
   input wire logic MEM_WE,
   input wire logic INT_ENABLE,
   input wire logic INT_ACCEPT,
   input wire logic HOLD_MODE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // Taken instruction, pending interrupt and release decode
   wire ien = INT_REQ && INT_ENABLE;
   wire go = INSTR_VALID && !HOLD_MODE && !ien && !RETURN_EXEC;
   wire rel = |(HOLD_RELEASE_EN & HOLD_RELEASE_EVENTS);
   wire dz = go && INSTR[15:7] == 9'h090;
   wire [6:0] adr = INSTR[6:0];
   AST_DEC_DATA: assert property (dz |=> MEM_WE && MEM_ADDR == $past(adr)
      && ACCUMULATOR == 4'($past(MEM_RDATA) - 4'h1) && MEM_WDATA == ACCUMULATOR) else $error("bad result");
   AST_DEC_FLAGS: assert property (dz |=> ZERO_FLAG == (ACCUMULATOR == 4'h0)
      && CARRY_FLAG == ($past(MEM_RDATA) != 4'h0)) else $error("bad flags");
   AST_SKIP: assert property (dz |=> PC == $past(PC) + ($past(MEM_RDATA) == 4'h1 ? 11'h002 : 11'h001))
      else $error("bad step");
   AST_INT_ON: assert property (go && INSTR == 16'h50e0 |=> INT_ENABLE) else $error("no enable");
   AST_INT_OFF: assert property (go && INSTR == 16'h50c0 |=> !INT_ENABLE) else $error("no disable");
   AST_HOLD_IN: assert property (go && INSTR == 16'h0080 |=> HOLD_MODE) else $error("no hold");
   AST_HOLD_KEEP: assert property (HOLD_MODE && !ien && !rel |=> HOLD_MODE && $stable(PC))
      else $error("hold left");
   AST_HOLD_INT: assert property (HOLD_MODE && ien |=> !HOLD_MODE && INT_ACCEPT && PC == $past(INT_VECTOR))
      else $error("bad wake");
   AST_HOLD_REL: assert property (HOLD_MODE && rel && !ien |=> !HOLD_MODE) else $error("no release");
   // Routine entered out of hold and not yet left
   logic woke_ff;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         woke_ff <= 1'b0;
      end else if (HOLD_MODE && ien) begin
         woke_ff <= 1'b1;
      end else if (RETURN_EXEC || rel || (INSTR_VALID && INSTR == 16'h0080)) begin
         woke_ff <= 1'b0;
      end
   end
   AST_RET_HOLD: assert property (woke_ff && RETURN_EXEC && !ien && !rel |=> HOLD_MODE)
      else $error("no hold after return");
   // Main scenarios
   cover property (dz && MEM_RDATA == 4'h1);
   cover property (HOLD_MODE && ien);
   cover property (HOLD_MODE && rel);
   cover property (woke_ff && RETURN_EXEC);
endmodule
bind dec_skip_int_enable_hold_exec exec_checker u_chk (.CLOCK, .RSTN, .INSTR_VALID, .INSTR, .MEM_RDATA,
   .INT_REQ, .INT_VECTOR, .RETURN_EXEC, .HOLD_RELEASE_EN, .HOLD_RELEASE_EVENTS, .PC, .ACCUMULATOR,
   .CARRY_FLAG, .ZERO_FLAG, .MEM_ADDR, .MEM_WDATA, .MEM_WE, .INT_ENABLE, .INT_ACCEPT, .HOLD_MODE);

// *** testbench/tb_top.sv ***
// Directed bench for the executor
`timescale 1ns/100ps
module tb_top;
   logic CLOCK = 1'b0;
   logic RSTN = 1'b0;
   logic INSTR_VALID = 1'b0;
   logic INT_REQ = 1'b0;
   logic RETURN_EXEC = 1'b0;
   logic [15:0] INSTR = 16'h0000;
   logic [3:0] MEM_RDATA = 4'h0;
   logic [10:0] INT_VECTOR = 11'h000;
   logic [10:0] ep = 11'h000;
   logic [7:0] HOLD_RELEASE_EN = 8'h00;
   logic [7:0] HOLD_RELEASE_EVENTS = 8'h00;
   logic [10:0] PC;
   logic [3:0] ACCUMULATOR;
   logic [3:0] MEM_WDATA;
   logic [6:0] MEM_ADDR;
   logic CARRY_FLAG, ZERO_FLAG, MEM_WE, INT_ENABLE, INT_ACCEPT, HOLD_MODE;
   int fails = 0;
   int cmp_count = 0;
   always #10 CLOCK = ~CLOCK;
   dec_skip_int_enable_hold_exec u_dut (.CLOCK, .RSTN, .INSTR_VALID, .INSTR, .MEM_RDATA, .INT_REQ,
      .INT_VECTOR, .RETURN_EXEC, .HOLD_RELEASE_EN, .HOLD_RELEASE_EVENTS, .PC, .ACCUMULATOR, .CARRY_FLAG,
      .ZERO_FLAG, .MEM_ADDR, .MEM_WDATA, .MEM_WE, .INT_ENABLE, .INT_ACCEPT, .HOLD_MODE);
   // Compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic step();
      @(posedge CLOCK);
      #1;
   endtask
   // Issue one word; valid stays up for back-to-back use
   task automatic issue(input logic [15:0] w, input logic [3:0] m);
      INSTR_VALID = 1'b1;
      INSTR = w;
      MEM_RDATA = m;
      step();
      ep = ep + 11'h001;
   endtask
   // Decrement to zero, from zero and plain, back to back
   task automatic t_dec();
      logic [3:0] m [3] = '{4'h1, 4'h0, 4'h6};
      for (int i = 0; i < 3; i++) begin
         issue(16'h4800 | 16'(i + 5), m[i]);
         if (m[i] == 4'h1) ep = ep + 11'h001;
         chk(PC, ep);
         chk({ACCUMULATOR, MEM_WDATA}, {2{4'(m[i] - 4'h1)}});
         chk({MEM_WE, MEM_ADDR, ZERO_FLAG, CARRY_FLAG}, {1'b1, 7'(i + 5), m[i] == 4'h1, m[i] != 4'h0});
      end
      INSTR_VALID = 1'b0;
      step();
      chk(MEM_WE, 1'b0);
   endtask
   task automatic t_ie();
      issue(16'h50e0, 4'h0);
      chk(INT_ENABLE, 1'b1);
      issue(16'h50c0, 4'h0);
      chk({INT_ENABLE, PC}, {1'b0, ep});
   endtask
   // Hold ignores words, masked events keep it, enabled event ends it
   task automatic t_rel();
      issue(16'h0080, 4'h0);
      issue(16'h50e0, 4'h0);
      ep = ep - 11'h001;
      chk({HOLD_MODE, INT_ENABLE, PC}, {2'b10, ep});
      INSTR_VALID = 1'b0;
      HOLD_RELEASE_EN = 8'h24;
      HOLD_RELEASE_EVENTS = 8'h18;
      step();
      chk(HOLD_MODE, 1'b1);
      HOLD_RELEASE_EVENTS = 8'h0c;
      step();
      chk(HOLD_MODE, 1'b0);
      HOLD_RELEASE_EN = 8'h00;
   endtask
   // Interrupt wakes hold, return goes back to hold
   task automatic t_isr();
      issue(16'h50e0, 4'h0);
      issue(16'h0080, 4'h0);
      INSTR_VALID = 1'b0;
      INT_VECTOR = 11'h2a5;
      INT_REQ = 1'b1;
      step();
      INT_REQ = 1'b0;
      chk({HOLD_MODE, INT_ACCEPT, PC}, {2'b01, 11'h2a5});
      RETURN_EXEC = 1'b1;
      step();
      RETURN_EXEC = 1'b0;
      chk({HOLD_MODE, PC}, {1'b1, ep});
   endtask
   // Release inside the routine cancels the return to hold
   task automatic t_isr_rel();
      INT_VECTOR = 11'h155;
      INT_REQ = 1'b1;
      step();
      INT_REQ = 1'b0;
      chk({HOLD_MODE, INT_ACCEPT, PC}, {2'b01, 11'h155});
      HOLD_RELEASE_EN = 8'h01;
      HOLD_RELEASE_EVENTS = 8'h01;
      step();
      HOLD_RELEASE_EN = 8'h00;
      HOLD_RELEASE_EVENTS = 8'h00;
      RETURN_EXEC = 1'b1;
      step();
      RETURN_EXEC = 1'b0;
      chk({HOLD_MODE, INT_ACCEPT, PC}, {2'b00, ep});
   endtask
   // Interrupt while running drops the word; return wins over a word
   task automatic t_run_int();
      INT_VECTOR = 11'h3c0;
      INT_REQ = 1'b1;
      issue(16'h4811, 4'h3);
      INT_REQ = 1'b0;
      ep = ep - 11'h001;
      chk({INT_ACCEPT, MEM_WE, PC}, {2'b10, 11'h3c0});
      chk(ACCUMULATOR, 4'h5);
      RETURN_EXEC = 1'b1;
      issue(16'h4811, 4'h3);
      RETURN_EXEC = 1'b0;
      INSTR_VALID = 1'b0;
      ep = ep - 11'h001;
      chk({INT_ACCEPT, MEM_WE, PC}, {2'b00, ep});
      chk(ACCUMULATOR, 4'h5);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Reset, then the scenarios
   initial begin
      repeat (20) @(posedge CLOCK);
      #1;
      RSTN = 1'b1;
      chk({PC, HOLD_MODE, INT_ENABLE, MEM_WE}, 16'h0000);
      t_dec();
      t_ie();
      t_rel();
      t_isr();
      t_isr_rel();
      t_run_int();
      complete_run();
   end
endmodule
